// ==== core/nsm_seq.sv ====
// Unsecure, backdoor key and user margin commands with an AXI4-Lite register slave
//
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module nsm_seq
    import nsm_pkg::*;
(
    input  wire logic          clk_sys_i,
    input  wire logic          nrst_i,
    input  wire logic [31:0]   s_axi_awaddr_i,
    input  wire logic          s_axi_awvalid_i,
    output logic               s_axi_awready_o,
    input  wire logic [31:0]   s_axi_wdata_i,
    input  wire logic [3:0]    s_axi_wstrb_i,
    input  wire logic          s_axi_wvalid_i,
    output logic               s_axi_wready_o,
    output logic [1:0]         s_axi_bresp_o,
    output logic               s_axi_bvalid_o,
    input  wire logic          s_axi_bready_i,
    input  wire logic [31:0]   s_axi_araddr_i,
    input  wire logic          s_axi_arvalid_i,
    output logic               s_axi_arready_o,
    output logic [31:0]        s_axi_rdata_o,
    output logic [1:0]         s_axi_rresp_o,
    output logic               s_axi_rvalid_o,
    input  wire logic          s_axi_rready_i,
    output logic               erase_all_req_o,
    input  wire nsm_mem_rsp_t  mem_rsp_i,
    output logic [15:0]        key_addr_o,
    input  wire logic [15:0]   key_data_i,
    output logic               secured_o,
    output logic [1:0]         flash_margin_o,
    output logic [1:0]         eeprom_margin_o
);
    logic              aw_ok_r;
    logic [7:0]        awaddr_r;
    logic              w_ok_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              rvalid_r;
    logic [1:0]        rresp_r;
    logic [31:0]       rdata_r;
    logic              command_complete_flag_r;
    logic              acc_r;
    logic              fpv_r;
    logic              mg1_r;
    logic              mg0_r;
    logic [2:0]        idx_r;
    logic [15:0]       buf_r [8];
    logic [1:0]        backdoor_key_enable_field_r;
    logic [2:0]        prot_r;
    logic              secured_r;
    logic              mismatch_r;
    logic [1:0]        flash_lvl_r;
    logic [1:0]        ee_lvl_r;
    logic [1:0]        kcnt_r;
    logic              kmatch_r;
    nsm_state_t        state_r;
    nsm_state_t        go_nxt;
    logic              l_acc;
    logic              l_fpv;
    logic              wr_fire;
    logic              wr_ok;
    logic              wr_map;
    logic              launch;
    logic [31:0]       rd_val;
    logic              rd_map;
    logic              key_eq;
    logic              mem_bad;
    logic [1:0]        lvl_code;

    assign s_axi_awready_o = !aw_ok_r;
    assign s_axi_wready_o  = !w_ok_r;
    assign s_axi_bvalid_o  = bvalid_r;
    assign s_axi_bresp_o   = bresp_r;
    assign s_axi_arready_o = !rvalid_r;
    assign s_axi_rvalid_o  = rvalid_r;
    assign s_axi_rresp_o   = rresp_r;
    assign s_axi_rdata_o   = rdata_r;
    assign secured_o       = secured_r;
    assign flash_margin_o  = flash_lvl_r;
    assign eeprom_margin_o = ee_lvl_r;
    assign erase_all_req_o = (state_r == NSM_ERASE);
    assign key_addr_o      = NSM_KEY_BASE + {13'h0, kcnt_r, 1'b0};
    assign mem_bad         = mem_rsp_i.err | mem_rsp_i.fatal;

    assign wr_map = (awaddr_r == NSM_OFS_STATUS) || (awaddr_r == NSM_OFS_INDEX) ||
                    (awaddr_r == NSM_OFS_DATA) || (awaddr_r == NSM_OFS_SECCFG) ||
                    (awaddr_r == NSM_OFS_PROT) || (awaddr_r == NSM_OFS_MARGIN);
    assign wr_fire = aw_ok_r && w_ok_r && !bvalid_r;
    // Writes while a command runs are dropped
    assign wr_ok   = wr_fire && command_complete_flag_r;
    assign launch  = wr_ok && (awaddr_r == NSM_OFS_STATUS) && wstrb_r[0] && wdata_r[NSM_ST_COMMAND_COMPLETE_FLAG] &&
                     !acc_r && !fpv_r;
    assign key_eq  = (key_data_i == buf_r[{1'b0, kcnt_r} + 3'h1]);
    assign lvl_code = buf_r[2][1:0];

    // AXI write address and data capture, in either order
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            aw_ok_r  <= 1'b0;
            awaddr_r <= 8'h00;
            w_ok_r   <= 1'b0;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
        end else begin
            if (s_axi_awvalid_i && !aw_ok_r) begin
                aw_ok_r  <= 1'b1;
                awaddr_r <= (s_axi_awaddr_i[31:8] == 24'h00_0000) ? {s_axi_awaddr_i[7:2], 2'b00} : 8'hFF;
            end else if (wr_fire) begin
                aw_ok_r <= 1'b0;
            end
            if (s_axi_wvalid_i && !w_ok_r) begin
                w_ok_r  <= 1'b1;
                wdata_r <= s_axi_wdata_i;
                wstrb_r <= s_axi_wstrb_i;
            end else if (wr_fire) begin
                w_ok_r <= 1'b0;
            end
        end
    end

    // AXI write response
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            bvalid_r <= 1'b0;
            bresp_r  <= NSM_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_map ? NSM_RESP_OKAY : NSM_RESP_SLV;
        end else if (s_axi_bready_i) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read mux
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_map = 1'b1;
        case ({s_axi_araddr_i[7:2], 2'b00})
            NSM_OFS_STATUS: rd_val = {24'h00_0000, command_complete_flag_r, 1'b0, acc_r, fpv_r, 2'b00, mg1_r, mg0_r};
            NSM_OFS_INDEX:  rd_val = {29'h0, idx_r};
            NSM_OFS_DATA:   rd_val = {16'h0000, buf_r[idx_r]};
            NSM_OFS_SECCFG: rd_val = {23'h0, secured_r, 6'h00, backdoor_key_enable_field_r};
            NSM_OFS_PROT:   rd_val = {29'h0, prot_r};
            NSM_OFS_MARGIN: rd_val = {24'h00_0000, 2'b00, ee_lvl_r, 2'b00, flash_lvl_r};
            default:        rd_map = 1'b0;
        endcase
        if (s_axi_araddr_i[31:8] != 24'h00_0000) begin
            rd_map = 1'b0;
            rd_val = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            rvalid_r <= 1'b0;
            rresp_r  <= NSM_RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
        end else if (s_axi_arvalid_i && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rresp_r  <= rd_map ? NSM_RESP_OKAY : NSM_RESP_SLV;
            rdata_r  <= rd_val;
        end else if (s_axi_rready_i) begin
            rvalid_r <= 1'b0;
        end
    end

    // Command buffer, one word per index, byte lanes 0 and 1
    for (genvar g = 0; g < 8; g++) begin : g_buf
        always_ff @(posedge clk_sys_i) begin
            if (!nrst_i) begin
                buf_r[g] <= 16'h0000;
            end else if (wr_ok && (awaddr_r == NSM_OFS_DATA) && (idx_r == 3'(g))) begin
                if (wstrb_r[0]) begin
                    buf_r[g][7:0] <= wdata_r[7:0];
                end
                if (wstrb_r[1]) begin
                    buf_r[g][15:8] <= wdata_r[15:8];
                end
            end
        end
    end

    // Index, key enable and protection configuration
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            idx_r   <= 3'h0;
            backdoor_key_enable_field_r <= NSM_BACKDOOR_KEY_ENABLE_FIELD_RST;
            prot_r  <= NSM_PROT_RST;
        end else if (wr_ok && wstrb_r[0]) begin
            if (awaddr_r == NSM_OFS_INDEX) begin
                idx_r <= wdata_r[2:0];
            end
            if (awaddr_r == NSM_OFS_SECCFG) begin
                backdoor_key_enable_field_r <= wdata_r[1:0];
            end
            if (awaddr_r == NSM_OFS_PROT) begin
                prot_r <= wdata_r[2:0];
            end
        end
    end

    // Launch checks
    always_comb begin
        l_acc  = 1'b0;
        l_fpv  = 1'b0;
        go_nxt = NSM_IDLE;
        case (buf_r[0][15:8])
            NSM_CMD_UNSEC: begin
                if (idx_r != NSM_IDX_UNSEC || prot_r[NSM_PR_NOUNSEC]) begin
                    l_acc = 1'b1;
                end else if (prot_r[NSM_PR_FLASH] || prot_r[NSM_PR_EEPROM]) begin
                    l_fpv = 1'b1;
                end else begin
                    go_nxt = NSM_ERASE;
                end
            end
            NSM_CMD_KEY: begin
                if (idx_r != NSM_IDX_KEY || backdoor_key_enable_field_r != NSM_BACKDOOR_KEY_ENABLE_FIELD_ON || mismatch_r) begin
                    l_acc = 1'b1;
                end else begin
                    go_nxt = NSM_KEY;
                end
            end
            NSM_CMD_MARGIN: begin
                if (idx_r != NSM_IDX_MARGIN) begin
                    l_acc = 1'b1;
                end else if (buf_r[2] != NSM_LVL_NORMAL && buf_r[2] != NSM_LVL_ERASED &&
                             buf_r[2] != NSM_LVL_PROG) begin
                    l_acc = 1'b1;
                end else begin
                    go_nxt = NSM_MARGIN;
                end
            end
            default: l_acc = 1'b1;
        endcase
    end

    // Sequencer state and key word counter
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            state_r  <= NSM_IDLE;
            kcnt_r   <= 2'h0;
            kmatch_r <= 1'b1;
        end else begin
            case (state_r)
                NSM_IDLE: begin
                    kcnt_r   <= 2'h0;
                    kmatch_r <= 1'b1;
                    if (launch) begin
                        state_r <= go_nxt;
                    end
                end
                NSM_ERASE: begin
                    if (mem_rsp_i.done) begin
                        state_r <= NSM_IDLE;
                    end
                end
                NSM_KEY: begin
                    kcnt_r   <= kcnt_r + 2'h1;
                    kmatch_r <= kmatch_r & key_eq;
                    if (kcnt_r == NSM_KEY_LAST) begin
                        state_r <= NSM_IDLE;
                    end
                end
                NSM_MARGIN: state_r <= NSM_IDLE;
                default:    state_r <= NSM_IDLE;
            endcase
        end
    end

    // Command complete flag
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            command_complete_flag_r <= 1'b1;
        end else if (launch && go_nxt != NSM_IDLE) begin
            command_complete_flag_r <= 1'b0;
        end else if ((state_r == NSM_ERASE && mem_rsp_i.done) ||
                     (state_r == NSM_KEY && kcnt_r == NSM_KEY_LAST) ||
                     state_r == NSM_MARGIN) begin
            command_complete_flag_r <= 1'b1;
        end
    end

    // Error flags: write one to clear, a set in the same cycle wins
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            acc_r <= 1'b0;
            fpv_r <= 1'b0;
        end else begin
            if ((launch && l_acc) ||
                (state_r == NSM_KEY && kcnt_r == NSM_KEY_LAST && !(kmatch_r & key_eq))) begin
                acc_r <= 1'b1;
            end else if (wr_ok && awaddr_r == NSM_OFS_STATUS && wstrb_r[0] && wdata_r[NSM_ST_ACC]) begin
                acc_r <= 1'b0;
            end
            if (launch && l_fpv) begin
                fpv_r <= 1'b1;
            end else if (wr_ok && awaddr_r == NSM_OFS_STATUS && wstrb_r[0] && wdata_r[NSM_ST_FPV]) begin
                fpv_r <= 1'b0;
            end
        end
    end

    // Verify result flags, cleared by each accepted launch
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            mg1_r <= 1'b0;
            mg0_r <= 1'b0;
        end else if (launch) begin
            mg1_r <= 1'b0;
            mg0_r <= 1'b0;
        end else if (state_r == NSM_ERASE && mem_rsp_i.done) begin
            mg1_r <= mem_bad;
            mg0_r <= mem_rsp_i.fatal;
        end
    end

    // Security state and sticky key mismatch
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            secured_r  <= 1'b1;
            mismatch_r <= 1'b0;
        end else begin
            if (state_r == NSM_ERASE && mem_rsp_i.done && !mem_bad) begin
                secured_r <= 1'b0;
            end
            if (state_r == NSM_KEY && kcnt_r == NSM_KEY_LAST) begin
                if (kmatch_r & key_eq) begin
                    secured_r <= 1'b0;
                end else begin
                    mismatch_r <= 1'b1;
                end
            end
        end
    end

    // User margin levels; the flash block setting also governs EEPROM reads
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            flash_lvl_r <= NSM_LVL_NORMAL[1:0];
            ee_lvl_r    <= NSM_LVL_NORMAL[1:0];
        end else if (state_r == NSM_MARGIN) begin
            ee_lvl_r <= lvl_code;
            if (!buf_r[0][7]) begin
                flash_lvl_r <= lvl_code;
            end
        end
    end
endmodule

// ==== pkg/nsm_pkg.sv ====
// Constants, types and register map of the security and margin command sequencer
package nsm_pkg;
    // Register byte offsets
    localparam logic [7:0]  NSM_OFS_STATUS = 8'h00;
    localparam logic [7:0]  NSM_OFS_INDEX  = 8'h04;
    localparam logic [7:0]  NSM_OFS_DATA   = 8'h08;
    localparam logic [7:0]  NSM_OFS_SECCFG = 8'h0C;
    localparam logic [7:0]  NSM_OFS_PROT   = 8'h10;
    localparam logic [7:0]  NSM_OFS_MARGIN = 8'h14;
    // Status field positions
    localparam int unsigned NSM_ST_COMMAND_COMPLETE_FLAG    = 7;
    localparam int unsigned NSM_ST_ACC     = 5;
    localparam int unsigned NSM_ST_FPV     = 4;
    localparam int unsigned NSM_ST_MG1     = 1;
    localparam int unsigned NSM_ST_MG0     = 0;
    // Security config and protection field positions
    localparam int unsigned NSM_SEC_SECURED = 8;
    localparam int unsigned NSM_PR_FLASH   = 0;
    localparam int unsigned NSM_PR_EEPROM  = 1;
    localparam int unsigned NSM_PR_NOUNSEC = 2;
    // Command codes and the index expected at launch
    localparam logic [7:0]  NSM_CMD_UNSEC  = 8'h0B;
    localparam logic [7:0]  NSM_CMD_KEY    = 8'h0C;
    localparam logic [7:0]  NSM_CMD_MARGIN = 8'h0D;
    localparam logic [2:0]  NSM_IDX_UNSEC  = 3'h0;
    localparam logic [2:0]  NSM_IDX_KEY    = 3'h4;
    localparam logic [2:0]  NSM_IDX_MARGIN = 3'h2;
    localparam logic [1:0]  NSM_BACKDOOR_KEY_ENABLE_FIELD_ON   = 2'h2;
    localparam logic [15:0] NSM_KEY_BASE   = 16'hFF70;
    localparam logic [1:0]  NSM_KEY_LAST   = 2'h3;
    // Margin level settings
    localparam logic [15:0] NSM_LVL_NORMAL = 16'h0000;
    localparam logic [15:0] NSM_LVL_ERASED = 16'h0001;
    localparam logic [15:0] NSM_LVL_PROG   = 16'h0002;
    // Reset values
    localparam logic [1:0]  NSM_BACKDOOR_KEY_ENABLE_FIELD_RST  = 2'h0;
    localparam logic [2:0]  NSM_PROT_RST   = 3'h0;
    // AXI responses
    localparam logic [1:0]  NSM_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  NSM_RESP_SLV   = 2'h2;

    typedef enum logic [1:0] {NSM_IDLE, NSM_ERASE, NSM_KEY, NSM_MARGIN} nsm_state_t;

    // Answer of the memory array to an erase-all request
    typedef struct packed {
        logic done;
        logic err;
        logic fatal;
    } nsm_mem_rsp_t;
endpackage

// ==== testbench/nsm_seq_props.sv ====
// Port assertions for the security and margin command sequencer
`timescale 1ns/1ps
module nsm_seq_props
    import nsm_pkg::*;
(
    input  wire logic         clk_sys_i,
    input  wire logic         nrst_i,
    input  wire logic         s_axi_rvalid_o,
    input  wire logic         s_axi_rready_i,
    input  wire logic         erase_all_req_o,
    input  wire nsm_mem_rsp_t mem_rsp_i,
    input  wire logic [15:0]  key_addr_o,
    input  wire logic         secured_o,
    input  wire logic [1:0]   flash_margin_o,
    input  wire logic [1:0]   eeprom_margin_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);
    sequence erase_end;
        erase_all_req_o && mem_rsp_i.done;
    endsequence
    sequence key_tail;
        key_addr_o == 16'hFF74 ##1 key_addr_o == 16'hFF76;
    endsequence
    erase_drop_a: assert property (erase_end |=> !erase_all_req_o)
        else $error("erase request held after done");
    unsec_pass_a: assert property (erase_end ##0 !(mem_rsp_i.err || mem_rsp_i.fatal) |=> !secured_o)
        else $error("security kept after clean erase");
    unsec_fail_a: assert property (erase_end ##0 (mem_rsp_i.err || mem_rsp_i.fatal) |=> $stable(secured_o))
        else $error("security dropped after failed verify");
    no_resecure_a: assert property ($past(nrst_i) |-> !$rose(secured_o))
        else $error("security engaged without reset");
    key_walk_a: assert property (key_addr_o == 16'hFF72 |=> key_tail)
        else $error("key address order broken");
    key_range_a: assert property (key_addr_o[15:3] == 13'h1FEE && !key_addr_o[0])
        else $error("key address outside key area");
    margin_code_a: assert property (flash_margin_o != 2'h3 && eeprom_margin_o != 2'h3)
        else $error("invalid margin level applied");
    flash_both_a: assert property ($changed(flash_margin_o) |-> eeprom_margin_o == flash_margin_o)
        else $error("flash margin not applied to eeprom");
    read_beat_a: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
        else $error("read data repeated");
endmodule

bind nsm_seq nsm_seq_props u_props (.clk_sys_i, .nrst_i, .s_axi_rvalid_o, .s_axi_rready_i, .erase_all_req_o,
    .mem_rsp_i, .key_addr_o, .secured_o, .flash_margin_o, .eeprom_margin_o);

// ==== testbench/nsm_seq_test.sv ====
// Self-checking bench for the security and margin command sequencer
`timescale 1ns/1ps
module nsm_seq_test;
    import nsm_pkg::*;
    logic         clk = 0, nrst = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [31:0]  awaddr = '0, wdata = '0, araddr = '0, rdata, s;
    logic         awr, wrdy, bv, arr, rv, erase, sec, e_err = 0, e_fat = 0;
    logic [1:0]   bresp, rresp, lr, lb, fm, em;
    logic [15:0]  kaddr;
    logic [2:0]   ecnt = '0;
    nsm_mem_rsp_t mem = '0;
    int           fails = 0, n_checks = 0, cyc = 0;

    always #2.5 clk = ~clk;
    nsm_seq u_dut (.clk_sys_i(clk), .nrst_i(nrst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .erase_all_req_o(erase),
        .mem_rsp_i(mem), .key_addr_o(kaddr), .key_data_i(kaddr ^ 16'h3C3C), .secured_o(sec),
        .flash_margin_o(fm), .eeprom_margin_o(em));

    // Memory array stand-in: erase finishes eight cycles after the request
    always @(posedge clk) begin
        ecnt <= erase ? ecnt + 3'h1 : 3'h0;
        mem  <= '{done: erase && ecnt == 3'h7, err: e_err, fatal: e_fat};
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rst;
        nrst <= 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic pa, pw;
        pa = 1;
        pw = 1;
        awaddr <= {24'h0, a};
        wdata  <= d;
        awv    <= 1'b1;
        wv     <= 1'b1;
        br     <= 1'b1;
        do begin
            @(posedge clk);
            if (pa && awr) begin
                awv <= 1'b0;
                pa = 0;
            end
            if (pw && wrdy) begin
                wv <= 1'b0;
                pw = 0;
            end
        end while (pa || pw);
        while (!bv) @(posedge clk);
        lb = bresp;
        br <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        araddr <= {24'h0, a};
        arv    <= 1'b1;
        rr     <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        while (!rv) @(posedge clk);
        d  = rdata;
        lr = rresp;
        rr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic ld(input logic [2:0] ix, input logic [15:0] d);
        wr(NSM_OFS_INDEX, {29'h0, ix});
        wr(NSM_OFS_DATA, {16'h0, d});
    endtask

    // Launch at index ix, wait for completion, compare status, then clear error flags
    task automatic run(input logic [2:0] ix, input logic [31:0] exp);
        wr(NSM_OFS_INDEX, {29'h0, ix});
        wr(NSM_OFS_STATUS, 32'h80);
        do rd(NSM_OFS_STATUS, s); while (!s[7]);
        chk(s, exp);
        wr(NSM_OFS_STATUS, 32'h30);
    endtask

    function automatic logic [15:0] kv(input int n);
        return (16'hFF70 + 16'(2 * n)) ^ 16'h3C3C;
    endfunction

    task automatic keys;
        ld(3'h0, 16'h0C00);
        for (int n = 0; n < 4; n++) ld(3'(n + 1), kv(n));
    endtask

    task automatic t_regs;
        rd(NSM_OFS_STATUS, s);
        chk(s, 32'h80);
        rd(NSM_OFS_SECCFG, s);
        chk(s, 32'h100);
        rd(8'h3C, s);
        chk({s[29:0], lr}, {30'h0, NSM_RESP_SLV});
        wr(8'h3C, 32'h0);
        chk({30'h0, lb}, {30'h0, NSM_RESP_SLV});
        wr(NSM_OFS_INDEX, 32'h0);
        chk({30'h0, lb}, {30'h0, NSM_RESP_OKAY});
        chk({28'h0, fm, em}, 32'h0);
        $display("register test done");
    endtask

    task automatic t_unsec_bad;
        ld(3'h0, 16'h0B00);
        wr(NSM_OFS_PROT, 32'h1);
        run(3'h0, 32'h90);
        wr(NSM_OFS_PROT, 32'h2);
        run(3'h0, 32'h90);
        wr(NSM_OFS_PROT, 32'h4);
        run(3'h0, 32'hA0);
        wr(NSM_OFS_PROT, 32'h0);
        run(3'h1, 32'hA0);
        ld(3'h0, 16'h0E00);
        run(3'h0, 32'hA0);
        $display("unsecure refusal test done");
    endtask

    task automatic t_unsec_run;
        ld(3'h0, 16'h0B00);
        e_err <= 1'b1;
        run(3'h0, 32'h82);
        chk({31'h0, sec}, 32'h1);
        e_fat <= 1'b1;
        run(3'h0, 32'h83);
        e_err <= 1'b0;
        e_fat <= 1'b0;
        wr(NSM_OFS_STATUS, 32'h80);
        wr(NSM_OFS_INDEX, 32'h5);
        do rd(NSM_OFS_STATUS, s); while (!s[7]);
        chk(s, 32'h80);
        rd(NSM_OFS_INDEX, s);
        chk(s, 32'h0);
        rd(NSM_OFS_SECCFG, s);
        chk(s, 32'h0);
        $display("unsecure run test done");
    endtask

    task automatic t_key;
        rst();
        keys();
        run(3'h4, 32'hA0);
        wr(NSM_OFS_SECCFG, 32'h2);
        run(3'h3, 32'hA0);
        ld(3'h2, ~kv(1));
        run(3'h4, 32'hA0);
        chk({31'h0, sec}, 32'h1);
        ld(3'h2, kv(1));
        run(3'h4, 32'hA0);
        rst();
        wr(NSM_OFS_SECCFG, 32'h2);
        keys();
        run(3'h4, 32'h80);
        rd(NSM_OFS_SECCFG, s);
        chk(s, 32'h2);
        $display("backdoor key test done");
    endtask

    task automatic t_margin;
        for (int l = 0; l < 3; l++) begin
            ld(3'h0, 16'h0D00);
            ld(3'h1, 16'h0);
            ld(3'h2, 16'(l));
            run(3'h2, 32'h80);
            chk({28'h0, fm, em}, 32'(l * 5));
            rd(NSM_OFS_MARGIN, s);
            chk(s, 32'(l * 17));
        end
        ld(3'h0, 16'h0D80);
        ld(3'h2, 16'h1);
        run(3'h2, 32'h80);
        chk({28'h0, fm, em}, 32'h9);
        ld(3'h2, 16'h3);
        run(3'h2, 32'hA0);
        ld(3'h2, 16'h0101);
        run(3'h2, 32'hA0);
        ld(3'h2, 16'h0);
        run(3'h1, 32'hA0);
        chk({28'h0, fm, em}, 32'h9);
        $display("margin test done");
    endtask

    initial begin
        rst();
        t_regs();
        t_unsec_bad();
        t_unsec_run();
        t_key();
        t_margin();
        tally_and_finish();
    end
endmodule
